//--- logic/pli_regs.vh
// Constants of the port lamp indicator: register offsets, fields, reset values, timing.
// Assumes a 40 MHz system clock and a word-wide AHB-Lite slave port.
`ifndef PLI_REGS_VH
`define PLI_REGS_VH

// ==========================================================================
// Register map.
`define PLI_PORT_STRIDE   8'h10
`define PLI_OFS_CTL1      4'h0
`define PLI_OFS_CTL2      4'h4
`define PLI_OFS_BASIC     4'h8
`define PLI_OFS_BEHAV     8'h40
`define PLI_OFS_PINCFG    8'h44
`define PLI_OFS_POL       8'h48
`define PLI_OFS_STATUS    8'h4c

// ==========================================================================
// Fields and reset values.
`define PLI_CTL1_LEGACY   6
`define PLI_CTL1_RST      8'h40
`define PLI_CTL2_RST      8'h00
`define PLI_BASIC_ISO     0
`define PLI_BASIC_PD      1
`define PLI_BEHAV_RST     8'h01
`define PLI_BEHAV_STR_EN  2
`define PLI_STATUS_STRAP  8
`define PLI_SPD_10        2'h0
`define PLI_SPD_100       2'h1
`define PLI_SPD_1000      2'h2

// Enhanced selections.
`define PLI_SEL_DUPLEX    4'h8
`define PLI_SEL_COLL      4'h9
`define PLI_SEL_ACT       4'ha
`define PLI_SEL_FAULT     4'hc
`define PLI_SEL_OFF       4'he
`define PLI_SEL_ON        4'hf

// ==========================================================================
// Timing: one lamp tick per millisecond, blink half periods in ticks.
`define PLI_CLK_KHZ       40000
`define PLI_TICK_US       1000
`define PLI_BLINK_HP0     8'h19
`define PLI_BLINK_HP1     8'h32
`define PLI_BLINK_HP2     8'h64
`define PLI_BLINK_HP3     8'hc8
`define PLI_STRETCH_TICKS 8'h28

`endif

//--- logic/pli_lamp_ctrl.v
// Port lamp indicator: AHB-Lite registers, scheme selection and lamp pin drivers.
// Assumes port status inputs come from logic on sys_clk; straps and hold-quiet are pins.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pli_regs.vh"

module pli_lamp_ctrl #(
  parameter PORTS    = 4,
  parameter TICK_CYC = (`PLI_TICK_US * `PLI_CLK_KHZ) / 1000
) (
  // Clock and reset.
  input  wire                 sys_clk,
  input  wire                 rst_b,
  // AHB-Lite slave.
  input  wire                 hsel,
  input  wire [7:0]           haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output reg  [31:0]          hrdata,
  output reg                  hreadyout,
  output reg                  hresp,
  // Port status, one bit or field per port.
  input  wire [PORTS-1:0]     link_up,
  input  wire [2*PORTS-1:0]   link_speed,
  input  wire [PORTS-1:0]     full_duplex,
  input  wire [PORTS-1:0]     activity,
  input  wire [PORTS-1:0]     collision,
  input  wire [PORTS-1:0]     pd_fault,
  // Pins: straps and hold-quiet.
  input  wire                 hold_quiet,
  input  wire                 lamp_style_strap,
  input  wire [2*PORTS-1:0]   lamp_polarity_strap,
  // Lamp pins, lamp one at bit 2p, lamp two at bit 2p+1.
  output reg  [2*PORTS-1:0]   lamp_out,
  output reg  [2*PORTS-1:0]   lamp_oe
);

  localparam NL = 2 * PORTS;

  // ==========================================================================
  // Pin synchronisers and strap capture.
  // Straps are caught on the third edge after reset release, once both stages hold a clean level.
  reg  [NL+1:0] pin_s1_q;
  reg  [NL+1:0] pin_s2_q;
  reg  [1:0]    strap_cnt_q;
  reg           style_q;
  reg  [NL-1:0] pol_q;
  wire          quiet = pin_s2_q[NL+1];

  always @(posedge sys_clk) begin
    pin_s1_q <= {hold_quiet, lamp_style_strap, lamp_polarity_strap};
    pin_s2_q <= pin_s1_q;
  end

  // ==========================================================================
  // AHB-Lite address phase capture; zero wait states, always OKAY.
  reg        wr_q;
  reg  [7:0] wa_q;
  wire       acc = hsel & htrans[1] & hready;
  wire [1:0] rp  = haddr[5:4];
  wire [3:0] ro  = haddr[3:0];
  wire [1:0] wp  = wa_q[5:4];
  wire [3:0] wo  = wa_q[3:0];
  wire       wport = wr_q & (wa_q[7:6] == 2'h0);

  reg  [7:0]    ctl1_q  [0:PORTS-1];
  reg  [7:0]    ctl2_q  [0:PORTS-1];
  reg  [1:0]    basic_q [0:PORTS-1];
  reg  [7:0]    behav_q;
  reg  [31:0]   pincfg_q;
  reg  [NL-1:0] on_q;
  integer       i;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_q      <= 1'b0;
      wa_q      <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      wr_q      <= acc & hwrite;
      if (acc)
        wa_q <= haddr;
      // Read data is settled in the address phase so the data phase carries it from a flop.
      hrdata <= 32'h0000_0000;
      if (acc & ~hwrite) begin
        if (haddr[7:6] == 2'h0 && ro == `PLI_OFS_CTL1)
          hrdata <= {24'h00_0000, ctl1_q[rp]};
        else if (haddr[7:6] == 2'h0 && ro == `PLI_OFS_CTL2)
          hrdata <= {24'h00_0000, ctl2_q[rp]};
        else if (haddr[7:6] == 2'h0 && ro == `PLI_OFS_BASIC)
          hrdata <= {30'h0, basic_q[rp]};
        else if (haddr == `PLI_OFS_BEHAV)
          hrdata <= {24'h00_0000, behav_q};
        else if (haddr == `PLI_OFS_PINCFG)
          hrdata <= pincfg_q;
        else if (haddr == `PLI_OFS_POL)
          hrdata <= {{(32-NL){1'b0}}, pol_q};
        else if (haddr == `PLI_OFS_STATUS)
          hrdata <= {23'h0, style_q, on_q};
      end
    end
  end

  // ==========================================================================
  // Register writes in the data phase.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      for (i = 0; i < PORTS; i = i + 1) begin
        ctl1_q[i]  <= `PLI_CTL1_RST;
        ctl2_q[i]  <= `PLI_CTL2_RST;
        basic_q[i] <= 2'h0;
      end
      behav_q     <= `PLI_BEHAV_RST;
      pincfg_q    <= 32'h0000_0000;
      pol_q       <= {NL{1'b0}};
      style_q     <= 1'b0;
      strap_cnt_q <= 2'h0;
    end else begin
      // Strap capture waits out the two synchroniser stages after release.
      if (strap_cnt_q != 2'h3)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        style_q <= pin_s2_q[NL];
        pol_q   <= ~pin_s2_q[NL-1:0];
      end
      if (wport && wo == `PLI_OFS_CTL1)
        ctl1_q[wp] <= hwdata[7:0];
      if (wport && wo == `PLI_OFS_CTL2)
        ctl2_q[wp] <= hwdata[7:0];
      if (wport && wo == `PLI_OFS_BASIC)
        basic_q[wp] <= hwdata[1:0];
      if (wr_q && wa_q == `PLI_OFS_BEHAV)
        behav_q <= hwdata[7:0];
      if (wr_q && wa_q == `PLI_OFS_PINCFG)
        pincfg_q <= hwdata;
      if (wr_q && wa_q == `PLI_OFS_POL && strap_cnt_q == 2'h3)
        pol_q <= hwdata[NL-1:0];
    end
  end

  // ==========================================================================
  // Millisecond tick and blink phase.
  // The tick is a one-cycle enable; every slower lamp rate counts these ticks.
  reg  [15:0] div_q;
  reg  [7:0]  blk_cnt_q;
  reg         blink_q;
  reg         tick_q;
  reg  [7:0]  half_p;

  always @* begin
    case (behav_q[1:0])
      2'h0:    half_p = `PLI_BLINK_HP0;
      2'h1:    half_p = `PLI_BLINK_HP1;
      2'h2:    half_p = `PLI_BLINK_HP2;
      default: half_p = `PLI_BLINK_HP3;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      div_q     <= 16'h0000;
      tick_q    <= 1'b0;
      blk_cnt_q <= 8'h00;
      blink_q   <= 1'b0;
    end else begin
      tick_q <= (div_q == TICK_CYC[15:0] - 16'h0001);
      if (div_q == TICK_CYC[15:0] - 16'h0001)
        div_q <= 16'h0000;
      else
        div_q <= div_q + 16'h0001;
      if (tick_q) begin
        if (blk_cnt_q >= half_p - 8'h01) begin
          blk_cnt_q <= 8'h00;
          blink_q   <= ~blink_q;
        end else begin
          blk_cnt_q <= blk_cnt_q + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Enhanced selection: source for one lamp from its four-bit field.
  function enh_lamp;
    input [3:0] sel;
    input       lnk;
    input [1:0] spd;
    input       act;
    input       fdx;
    input       col;
    input       flt;
    input       blk;
    reg   [2:0] mask;
    reg         hit;
    begin
      case (sel)
        4'h0:    mask = 3'b111;
        4'h1:    mask = 3'b100;
        4'h2:    mask = 3'b010;
        4'h3:    mask = 3'b001;
        4'h4:    mask = 3'b110;
        4'h5:    mask = 3'b101;
        4'h6:    mask = 3'b011;
        default: mask = 3'b000;
      endcase
      hit = lnk & ((spd == `PLI_SPD_1000 & mask[2]) | (spd == `PLI_SPD_100 & mask[1]) |
                   (spd == `PLI_SPD_10 & mask[0]));
      case (sel)
        `PLI_SEL_DUPLEX: enh_lamp = lnk & (fdx | (col & blk));
        `PLI_SEL_COLL:   enh_lamp = col & blk;
        `PLI_SEL_ACT:    enh_lamp = act & blk;
        `PLI_SEL_FAULT:  enh_lamp = flt;
        `PLI_SEL_OFF:    enh_lamp = 1'b0;
        `PLI_SEL_ON:     enh_lamp = 1'b1;
        default:         enh_lamp = hit & (~act | blk);
      endcase
    end
  endfunction

  // ==========================================================================
  // Per-port activity stretch, scheme choice and lamp state.
  wire [NL-1:0] lamp_on;
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      reg  [7:0] str_q;
      reg  [7:0] cstr_q;
      wire       legacy = ctl1_q[p][`PLI_CTL1_LEGACY];
      wire [1:0] spd    = link_speed[2*p+1:2*p];
      wire       str_en = behav_q[`PLI_BEHAV_STR_EN];
      wire       act    = activity[p] | (str_en & (str_q != 8'h00));
      wire       col    = collision[p] & ~full_duplex[p] | (str_en & (cstr_q != 8'h00));
      wire       lnk    = link_up[p];
      wire       lit    = ~act | blink_q;
      wire       kill   = basic_q[p][`PLI_BASIC_ISO] | basic_q[p][`PLI_BASIC_PD] | quiet;
      reg        one;
      reg        two;

      // Stretch keeps short bursts visible for at least one blink phase at the fastest blink rate only.
      always @(posedge sys_clk) begin
        if (!rst_b) begin
          str_q  <= 8'h00;
          cstr_q <= 8'h00;
        end else begin
          if (activity[p])
            str_q <= `PLI_STRETCH_TICKS;
          else if (tick_q && str_q != 8'h00)
            str_q <= str_q - 8'h01;
          if (collision[p] & ~full_duplex[p])
            cstr_q <= `PLI_STRETCH_TICKS;
          else if (tick_q && cstr_q != 8'h00)
            cstr_q <= cstr_q - 8'h01;
        end
      end

      always @* begin
        if (legacy && style_q) begin
          two = lnk;
          one = lnk & act & blink_q;
        end else if (legacy) begin
          two = lnk & (spd == `PLI_SPD_1000 | spd == `PLI_SPD_10) & lit;
          one = lnk & (spd == `PLI_SPD_100 | spd == `PLI_SPD_10) & lit;
        end else begin
          one = enh_lamp(ctl2_q[p][3:0], lnk, spd, act, full_duplex[p], col, pd_fault[p],
                         blink_q);
          two = enh_lamp(ctl2_q[p][7:4], lnk, spd, act, full_duplex[p], col, pd_fault[p],
                         blink_q);
        end
      end

      assign lamp_on[2*p]   = one & ~kill;
      assign lamp_on[2*p+1] = two & ~kill;
    end
  endgenerate

  // ==========================================================================
  // Pin drivers. Pin config holds enable, lamp function, output and open-drain bytes.
  // Open-drain drive only ever drives the active level, so an inverted lamp still works.
  wire [NL-1:0] pin_en  = pincfg_q[NL-1:0] & pincfg_q[8+NL-1:8] & pincfg_q[16+NL-1:16];
  wire [NL-1:0] pin_od  = pincfg_q[24+NL-1:24];
  wire [NL-1:0] level   = ~(lamp_on ^ pol_q);

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      lamp_out <= {NL{1'b0}};
      lamp_oe  <= {NL{1'b0}};
      on_q     <= {NL{1'b0}};
    end else begin
      on_q     <= lamp_on;
      lamp_out <= level & pin_en;
      lamp_oe  <= pin_en & (~pin_od | lamp_on);
    end
  end

endmodule // pli_lamp_ctrl

//--- verif/pli_lamp_board.sv
// Board lamps on the eight lamp pins, each pin also carrying its strap resistor.
// Assumes pol = ~strap, so a released pin rests at its off level.
`timescale 1ns/1ps
// ====
// Lamp model.
module pli_lamp_board (
  // Pins.
  input  wire [7:0] lamp_out,
  input  wire [7:0] lamp_oe,
  // Strap resistor levels.
  input  wire [7:0] pull_lvl,
  // Lamp state.
  output wire [7:0] lit
);
  // Undriven pins fall to the resistor, never to a stale driven value.
  wire [7:0] pin_lvl = (lamp_out & lamp_oe) | (pull_lvl & ~lamp_oe);
  assign lit = pin_lvl ^ pull_lvl;
endmodule // pli_lamp_board

//--- verif/pli_lamp_properties.sv
// Port-level checker of the lamp block, bound into pli_lamp_ctrl.
// Assumes the polarity register keeps its strap default.
`timescale 1ns/1ps
// ====
// Checker.
module pli_lamp_props #(
  parameter PORTS = 4
) (
  // Clock and reset.
  input wire               sys_clk,
  input wire               rst_b,
  // Bus.
  input wire               hsel,
  input wire [1:0]         htrans,
  input wire               hready,
  input wire [31:0]        hrdata,
  input wire               hreadyout,
  input wire               hresp,
  // Lamps.
  input wire               hold_quiet,
  input wire [2*PORTS-1:0] lamp_polarity_strap,
  input wire [2*PORTS-1:0] lamp_out,
  input wire [2*PORTS-1:0] lamp_oe
);
  // A driven pin at its strap level is dark.
  wire xfer = hsel & htrans[1] & hready;
  wire dark = ((lamp_out ^ lamp_polarity_strap) & lamp_oe) == 0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_RST_DARK: assert property ($rose(rst_b) |-> lamp_oe == 0 && !hreadyout)
    else $error("lamps or ready active straight after reset");
  AST_READY_UP: assert property ($rose(rst_b) |=> hreadyout)
    else $error("ready not raised after reset");
  AST_READY_HOLD: assert property (hreadyout |=> hreadyout)
    else $error("wait state inserted");
  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  AST_RDATA_IDLE: assert property (!xfer |=> hrdata == 32'h0)
    else $error("read data without a transfer");
  AST_QUIET_DARK: assert property (hold_quiet [*5] |-> dark)
    else $error("lamp lit while held quiet");
  AST_QUIET_ENTRY: assert property ($rose(hold_quiet) |-> ##[1:6] dark)
    else $error("lamps not forced off");
  AST_QUIET_STILL: assert property (hold_quiet [*6] |-> $stable(lamp_out))
    else $error("lamp pin moved while held quiet");
endmodule // pli_lamp_props

bind pli_lamp_ctrl pli_lamp_props #(.PORTS(PORTS)) i_pli_lamp_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hold_quiet(hold_quiet),
  .lamp_polarity_strap(lamp_polarity_strap), .lamp_out(lamp_out), .lamp_oe(lamp_oe));

//--- verif/testbench.sv
// Self-checking bench: AHB-Lite master, random port status, lamps seen through the board.
// Assumes one 40 MHz clock and a 4-cycle lamp tick.
`timescale 1ns/1ps
`include "pli_regs.vh"
module testbench;
  reg         sys_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         hsel = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [3:0]  link_up = 4'h0, full_duplex = 4'h0, activity = 4'h0;
  reg  [3:0]  collision = 4'h0, pd_fault = 4'h0;
  reg  [7:0]  link_speed = 8'h00, pol_strap = 8'h00;
  reg         hold_quiet = 1'b0, style = 1'b1;
  wire [31:0] hrdata;
  wire        hreadyout, hresp;
  wire [7:0]  lamp_out, lamp_oe, lit;
  integer     errors = 0, check_count = 0, seed_v;
  // Lamp tick in clock cycles, shortened so that blink phases fit a short run.
  localparam int TB_TICK = 4;

  // ====
  // Design and board.
  pli_lamp_ctrl #(.PORTS(4), .TICK_CYC(TB_TICK)) i_pli_lamp_ctrl (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_up(link_up), .link_speed(link_speed),
    .full_duplex(full_duplex), .activity(activity), .collision(collision),
    .pd_fault(pd_fault), .hold_quiet(hold_quiet), .lamp_style_strap(style),
    .lamp_polarity_strap(pol_strap), .lamp_out(lamp_out), .lamp_oe(lamp_oe));
  pli_lamp_board i_pli_lamp_board (.lamp_out(lamp_out), .lamp_oe(lamp_oe),
    .pull_lvl(pol_strap), .lit(lit));

  // Clock, 25 ns period.
  initial forever #12.5 sys_clk = ~sys_clk;

  // ====
  // Checking and closing.
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One single transfer; entered right after a rising edge, waits on ready.
  task ahb(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  // Lamp code 0 off, 1 steady, 2 blinking; speed sets packed three bits per selection.
  function [1:0] want_lamp(input [1:0] md, input two, input [3:0] sel, input l,
      input [1:0] s, input a, input f, input c, input d);
    reg [1:0] st;
    reg [23:0] sets;
    st = l ? (a ? 2'd2 : 2'd1) : 2'd0;
    sets = 24'h0ee2a7;
    if (md == 2'd0) want_lamp = two ? {1'b0, l} : (a ? 2'd2 : 2'd0);
    else if (md == 2'd1) want_lamp = (s == 2'd0 || (s == 2'd2) == two) ? st : 2'd0;
    else if (sel < 4'h7) want_lamp = sets[3*sel + s] ? st : 2'd0;
    else if (sel == `PLI_SEL_DUPLEX) want_lamp = (l & f) ? 2'd1 : (c ? 2'd2 : 2'd0);
    else if (sel == `PLI_SEL_COLL) want_lamp = c ? 2'd2 : 2'd0;
    else if (sel == `PLI_SEL_ACT) want_lamp = a ? 2'd2 : 2'd0;
    else if (sel == `PLI_SEL_FAULT) want_lamp = {1'b0, d};
    else want_lamp = {1'b0, sel == `PLI_SEL_ON};
  endfunction

  // Watch the lamps for longer than one blink period.
  task observe(output [15:0] code);
    reg [7:0] s1, s0;
    s1 = 0;
    s0 = 0;
    repeat (260) begin
      @(posedge sys_clk);
      s1 = s1 | lit;
      s0 = s0 | ~lit;
    end
    for (int i = 0; i < 8; i++) code[2*i +: 2] = (s1[i] & s0[i]) ? 2'd2 : {1'b0, s1[i]};
  endtask

  // Expected blink half period in clock cycles for a rate field.
  function integer want_half(input [1:0] m);
    case (m)
      2'd0:    want_half = `PLI_BLINK_HP0 * TB_TICK;
      2'd1:    want_half = `PLI_BLINK_HP1 * TB_TICK;
      2'd2:    want_half = `PLI_BLINK_HP2 * TB_TICK;
      default: want_half = `PLI_BLINK_HP3 * TB_TICK;
    endcase
  endfunction

  // Cycles between two edges of lamp zero; the first, partial phase is thrown away.
  task half_period(output integer n);
    reg prev;
    n = 0;
    repeat (2) begin
      prev = lit[0];
      n = 0;
      while (lit[0] === prev && n < 2000) begin
        @(posedge sys_clk);
        n++;
      end
    end
  endtask

  // Blink rates and activity stretch on ports 0 and 1, lamp one showing activity.
  task behav_checks;
    integer n, hi, lo;
    reg [31:0] v;
    hold_quiet <= 1'b0;
    activity <= 4'h3;
    for (int p = 0; p < 2; p++) begin
      ahb(1'b1, 16*p + `PLI_OFS_CTL1, 0, v);
      ahb(1'b1, 16*p + `PLI_OFS_CTL2, {24'h0, `PLI_SEL_OFF, `PLI_SEL_ACT}, v);
      ahb(1'b1, 16*p + `PLI_OFS_BASIC, 0, v);
    end
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, `PLI_OFS_BEHAV, m, v);
      half_period(n);
      chk("half_period", n, want_half(m));
    end
    // Port 0 goes quiet long enough for any old stretch to run out first.
    activity <= 4'h2;
    ahb(1'b1, `PLI_OFS_BEHAV, 32'h4, v);
    repeat (200) @(posedge sys_clk);
    // A one-cycle burst at the start of a dark phase is only visible if stretched.
    n = 0;
    while (lit[2] !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    while (lit[2] !== 1'b0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    activity <= 4'h3;
    @(posedge sys_clk);
    activity <= 4'h2;
    hi = 0;
    lo = 0;
    repeat (200) begin
      @(posedge sys_clk);
      hi = hi | lit[0];
    end
    repeat (200) begin
      @(posedge sys_clk);
      lo = lo | lit[0];
    end
    chk("stretch_on", hi, 1);
    chk("stretch_off", lo, 0);
  endtask

  // One reset with a given style strap, then random traffic on all ports.
  task run_phase(input s);
    reg [31:0] r, r2, r3, v;
    reg [15:0] got, want;
    reg [7:0]  bo;
    r = $urandom;
    rst_b <= 1'b0;
    hold_quiet <= 1'b0;
    style <= s;
    pol_strap <= r[7:0];
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ahb(1'b0, `PLI_OFS_STATUS, 0, v);
    chk("style", v[8], s);
    ahb(1'b0, 8'h20 + `PLI_OFS_CTL1, 0, v);
    chk("ctl1", v, `PLI_CTL1_RST);
    ahb(1'b0, `PLI_OFS_BEHAV, 0, v);
    chk("behav", v, `PLI_BEHAV_RST);
    ahb(1'b0, `PLI_OFS_POL, 0, v);
    chk("pol", v, ~r[7:0] & 8'hff);
    ahb(1'b0, 8'h80, 0, v);
    chk("unmapped", v, 0);
    chk("idle_oe", lamp_oe, 0);
    ahb(1'b1, `PLI_OFS_PINCFG, {r[15:8], 24'hffffff}, v);
    ahb(1'b1, `PLI_OFS_BEHAV, 0, v);
    for (int it = 0; it < 16; it++) begin
      r = $urandom;
      r2 = $urandom;
      r3 = $urandom;
      bo = r3[15:8] & r3[23:16] & r3[31:24];
      for (int p = 0; p < 4; p++) begin
        ahb(1'b1, 16*p + `PLI_OFS_CTL1, {25'h0, r[20+p], 6'h0}, v);
        ahb(1'b1, 16*p + `PLI_OFS_CTL2, {24'h0, r2[8*p +: 8]}, v);
        ahb(1'b1, 16*p + `PLI_OFS_BASIC, {30'h0, bo[2*p +: 2]}, v);
        link_speed[2*p +: 2] <= r3[2*p +: 2] % 3;
      end
      link_up <= r[3:0];
      full_duplex <= r[7:4];
      activity <= r[11:8] & r[3:0];
      collision <= r[15:12] & r[3:0] & ~r[7:4];
      pd_fault <= r[19:16];
      hold_quiet <= r[26:24] == 3'h0;
      repeat (6) @(posedge sys_clk);
      observe(got);
      for (int k = 0; k < 8; k++) begin
        want[2*k +: 2] = (hold_quiet || bo[k & 6] || bo[k | 1]) ? 2'd0 :
          want_lamp(r[20 + k/2] ? {1'b0, ~s} : 2'd2, k[0], r2[4*k +: 4], link_up[k/2],
          link_speed[k & 6 +: 2], activity[k/2], full_duplex[k/2], collision[k/2],
          pd_fault[k/2]);
      end
      chk("lamps", got, want);
      // Steady lamps must read back the same on state in the status word.
      ahb(1'b0, `PLI_OFS_STATUS, 0, v);
      for (int k = 0; k < 8; k++)
        if (want[2*k +: 2] != 2'd2) chk("status_on", v[k], want[2*k]);
    end
  endtask

  // Main sequence.
  initial begin
    seed_v = $urandom(39975);
    @(posedge sys_clk);
    run_phase(1'b1);
    run_phase(1'b0);
    behav_checks;
    tally_and_finish;
  end

  // Watchdog well beyond two phases of traffic.
  initial begin
    #(60000 * 25);
    errors++;
    tally_and_finish;
  end
endmodule // testbench
